/* File: core/float_ambient_sequencer.sv */
// float ambient measurement sequencer with per-slot configuration registers
// Functional notes
// - second pulse minus first pulse result
// - only first pulse float differs; later use period
// - any pulse count sums all pulse results
// - zero emitter choice places slot in float
// - float enable value three floats photodiode
// - math value two: subtract first, add second
// - amp reference value two selects 0.9 V
// - cathode value two gives 250 mV bias
// - override bit selects per-slot cathode fields
// - precondition time precedes first float interval
// - 10-bit float period, high bits shared
// - connect width sets charge dump time
// - first float equals offset plus width minus precondition
// - integrator start counted in 31.25 ns steps
// - result spans second float minus first float
// - whole charge dump in negative integration phase
`timescale 1ns/1ps
module float_ambient_sequencer
    import float_seq_pkg::*;
#(
    parameter int RESULT_W = 20,  // per-pulse result width
    parameter int ACC_W    = 27   // sample accumulator width
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    input  wire logic [7:0]            regAddr,
    input  wire logic [REG_DATA_W-1:0] regWrData,
    output logic      [REG_DATA_W-1:0] regRdData,
    input  wire logic                  sampleStart,
    input  wire logic                  slotSelB,
    input  wire logic                  adcValid,
    input  wire logic [RESULT_W-1:0]   adcResult,
    output logic                       busy,
    output logic                       preconditionOn,
    output logic                       pdFloating,
    output logic                       pdConnected,
    output logic                       integratorPositive,
    output logic                       integratorNegative,
    output logic                       adcRequest,
    output logic      [1:0]            ampReferenceLevel,
    output logic                       ampReference0v9,
    output logic      [1:0]            cathodeBiasLevel,
    output logic                       reverseBias250mV,
    output logic                       sampleValid,
    output logic                       sampleSlotB,
    output logic      [ACC_W-1:0]      sampleData
);

    localparam int DIV_W = $clog2(US_CYCLES);   // microsecond divider width
    localparam int CYC_W = 16;                  // float cycle counter width

    // host-visible settings kept as flops for the sequencer
    typedef struct packed {
        logic [15:0] ledSelect;
        logic [15:0] aTiming;
        logic [15:0] aPeriod;
        logic [15:0] bTiming;
        logic [15:0] bPeriod;
        logic [15:0] periodHigh;
        logic [15:0] aIntegrator;
        logic [15:0] bIntegrator;
        logic [15:0] defaultCathode;
        logic [15:0] aAmpRef;
        logic [15:0] bAmpRef;
        logic [15:0] cathodeBias;
        logic [15:0] pulseMath;
        logic [15:0] bFloatCtrl;
        logic [15:0] aFloatCtrl;
    } settings_t;

    // whole module state
    typedef struct packed {
        seq_state_t      state;
        logic            slotB;
        logic [7:0]      pulseIdx;
        logic [9:0]      usLeft;
        logic [4:0]      negLeft;
        logic [DIV_W-1:0] divCnt;
        logic [CYC_W-1:0] floatCyc;
        logic [ACC_W-1:0] acc;
        logic            adcReq;
        logic            sampleValid;
        logic [ACC_W-1:0] sampleData;
        logic            rdStatus;
        logic            rdMapped;
        logic [15:0]     statusSnap;
        settings_t       cfg;
    } state_t;

    state_t q;                       // registered state
    state_t d;                       // next state
    logic [REG_DATA_W-1:0] memRdData; // stored register read data

    // decoded per-slot fields
    logic        curB;
    logic [1:0]  ledSel;
    logic [1:0]  floatEn;
    logic [4:0]  precon;
    logic [9:0]  period;
    logic [7:0]  pulses;
    logic [7:0]  effPulses;
    logic [4:0]  connW;
    logic [7:0]  dumpOffset;
    logic [4:0]  intW;
    logic [10:0] intStart;
    logic [1:0]  mathSel;
    logic [1:0]  ampRef;
    logic [1:0]  cathSel;
    logic        slotFloat;
    logic [10:0] float1Raw;
    logic [9:0]  float1;
    logic [31:0] startCycWide;
    logic [CYC_W-1:0] startCyc;
    logic        tick;
    logic        subtractNow;
    logic [ACC_W-1:0] pulseExt;
    logic [ACC_W-1:0] accNext;

    // true for every address held in register storage
    function automatic logic isMapped(input logic [7:0] a);
        unique case (a)
            OFF_SLOT_LED_SELECT, OFF_SLOT_A_LED_TIMING, OFF_SLOT_A_PULSE_PERIOD,
            OFF_SLOT_B_LED_TIMING, OFF_SLOT_B_PULSE_PERIOD, OFF_PERIOD_HIGH_BITS,
            OFF_SLOT_A_INTEGRATOR, OFF_SLOT_B_INTEGRATOR, OFF_DEFAULT_CATHODE,
            OFF_SLOT_A_AMP_REF, OFF_SLOT_A_FRONTEND, OFF_SLOT_B_AMP_REF,
            OFF_SLOT_B_FRONTEND, OFF_CATHODE_BIAS, OFF_PULSE_MATH,
            OFF_SLOT_B_FLOAT_CTRL, OFF_SLOT_A_FLOAT_CTRL: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // picks the slot B or slot A copy of a register
    function automatic logic [15:0] pick(input logic b, input logic [15:0] va,
                                         input logic [15:0] vb, input int lsb);
        pick = (b ? vb : va) >> lsb;
    endfunction

    // sign of a pulse result from the first/second pulse math field
    function automatic logic pulseSubtract(input logic [1:0] m, input logic [7:0] idx);
        if (idx == 8'h00) begin
            pulseSubtract = (m == MATH_SUB1_ADD2);
        end else if (idx == 8'h01) begin
            pulseSubtract = (m == MATH_ADD1_SUB2);
        end else begin
            pulseSubtract = 1'b0;
        end
    endfunction

    // register storage serving host reads
    reg_store #(
        .ADDR_W (REG_ADDR_W),
        .DATA_W (REG_DATA_W)
    ) u_store (
        .clock  (clock),
        .srst   (srst),
        .wrEn   (regWrEn && isMapped(regAddr)),
        .wrAddr (regAddr[REG_ADDR_W-1:0]),
        .wrData (regWrData),
        .rdEn   (regRdEn),
        .rdAddr (regAddr[REG_ADDR_W-1:0]),
        .rdData (memRdData)
    );

    // field decode for the slot in use
    always_comb begin
        curB       = (q.state == ST_IDLE) ? slotSelB : q.slotB;
        // each slot reads its own fields, except the cathode override bit both slots share
        ledSel     = curB ? q.cfg.ledSelect[LEDSEL_B_LSB +: 2]
                          : q.cfg.ledSelect[LEDSEL_A_LSB +: 2];
        floatEn    = 2'(pick(curB, q.cfg.aFloatCtrl, q.cfg.bFloatCtrl, FLTEN_LSB));
        precon     = 5'(pick(curB, q.cfg.aFloatCtrl, q.cfg.bFloatCtrl, PRECON_LSB));
        // low byte per slot, high pair from the shared register
        period     = {curB ? q.cfg.periodHigh[PERIOD_HI_B_LSB +: 2]
                           : q.cfg.periodHigh[PERIOD_HI_A_LSB +: 2],
                      8'(pick(curB, q.cfg.aPeriod, q.cfg.bPeriod, PERIOD_LO_LSB))};
        pulses     = 8'(pick(curB, q.cfg.aPeriod, q.cfg.bPeriod, PULSES_LSB));
        effPulses  = (pulses == 8'h00) ? 8'h01 : pulses;
        connW      = 5'(pick(curB, q.cfg.aTiming, q.cfg.bTiming, CONNW_LSB));
        dumpOffset = 8'(pick(curB, q.cfg.aTiming, q.cfg.bTiming, OFFSET_LSB));
        intW       = 5'(pick(curB, q.cfg.aIntegrator, q.cfg.bIntegrator, INTW_LSB));
        intStart   = 11'(pick(curB, q.cfg.aIntegrator, q.cfg.bIntegrator, INTSTART_LSB));
        mathSel    = curB ? q.cfg.pulseMath[MATH_B_LSB +: 2]
                          : q.cfg.pulseMath[MATH_A_LSB +: 2];
        ampRef     = 2'(pick(curB, q.cfg.aAmpRef, q.cfg.bAmpRef, AMPREF_LSB));
        // override bit chooses per-slot cathode fields over the default register
        if (q.cfg.cathodeBias[CATH_OVR_BIT]) begin
            cathSel = curB ? q.cfg.cathodeBias[CATH_B_LSB +: 2]
                           : q.cfg.cathodeBias[CATH_A_LSB +: 2];
        end else begin
            cathSel = curB ? q.cfg.defaultCathode[DEFCATH_B_LSB +: 2]
                           : q.cfg.defaultCathode[DEFCATH_A_LSB +: 2];
        end
        // float only with emitter choice zero and float enable three
        slotFloat  = (ledSel == LED_SEL_FLOAT) && (floatEn == FLOAT_ENABLE_ON);
        // first float = offset + connect width - precondition, floored at zero
        float1Raw  = {3'h0, dumpOffset} + {6'h00, connW} - {6'h00, precon};
        float1     = float1Raw[10] ? 10'h000 : float1Raw[9:0];
        // integrator start steps converted to clock cycles
        startCycWide = (32'(intStart) * 32'(INT_STEP_PS)) / 32'(CLOCK_PERIOD_PS);
        startCyc   = startCycWide[CYC_W-1:0];
        tick       = (q.divCnt == DIV_W'(US_CYCLES - 1));
        subtractNow = pulseSubtract(mathSel, q.pulseIdx);
        pulseExt   = ACC_W'($signed(adcResult));
        accNext    = subtractNow ? (q.acc - pulseExt) : (q.acc + pulseExt);
    end

    // next-state logic: sequencer, divider, host register writes and reads
    always_comb begin
        d = q;
        d.adcReq      = 1'b0;
        d.sampleValid = 1'b0;
        // microsecond enable divider runs only while sequencing
        if (q.state != ST_IDLE) begin
            d.divCnt = tick ? '0 : q.divCnt + 1'b1;
        end
        // cycles since the float interval began, saturating
        if (q.state == ST_FLOAT && q.floatCyc != '1) begin
            d.floatCyc = q.floatCyc + 1'b1;
        end
        // negative phase runs through connect and its tail
        if ((q.state == ST_CONNECT || q.state == ST_NEGTAIL) && tick && q.negLeft != 5'h00) begin
            d.negLeft = q.negLeft - 1'b1;
        end
        unique case (q.state)
            ST_IDLE: begin
                // a start for a slot not in float mode is ignored
                if (sampleStart && slotFloat) begin
                    d.slotB    = slotSelB;
                    d.acc      = '0;
                    d.pulseIdx = 8'h00;
                    d.usLeft   = {5'h00, precon};
                    d.divCnt   = '0;
                    d.state    = ST_PRECON;
                end
            end
            ST_PRECON: begin
                // precondition ends, first float begins
                if (q.usLeft == 10'h000) begin
                    d.usLeft   = float1;
                    d.divCnt   = '0;
                    d.floatCyc = '0;
                    d.state    = ST_FLOAT;
                end else if (tick) begin
                    d.usLeft = q.usLeft - 1'b1;
                end
            end
            ST_FLOAT: begin
                // float over: connect the diode and start the negative phase
                if (q.usLeft == 10'h000) begin
                    d.usLeft  = {5'h00, connW};
                    d.negLeft = intW;
                    d.divCnt  = '0;
                    d.state   = ST_CONNECT;
                end else if (tick) begin
                    d.usLeft = q.usLeft - 1'b1;
                end
            end
            ST_CONNECT: begin
                // charge dump window
                if (q.usLeft == 10'h000) begin
                    d.state = ST_NEGTAIL;
                end else if (tick) begin
                    d.usLeft = q.usLeft - 1'b1;
                end
            end
            ST_NEGTAIL: begin
                // integrator finishes the negative phase, then conversion
                if (q.negLeft == 5'h00) begin
                    d.adcReq = 1'b1;
                    d.state  = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                // add or subtract this pulse, then next pulse or finish
                if (adcValid) begin
                    d.acc      = accNext;
                    d.pulseIdx = q.pulseIdx + 1'b1;
                    if (q.pulseIdx + 8'h01 >= effPulses) begin
                        d.sampleData  = accNext;
                        d.sampleValid = 1'b1;
                        d.state       = ST_IDLE;
                    end else begin
                        d.usLeft   = period;
                        d.divCnt   = '0;
                        d.floatCyc = '0;
                        d.state    = ST_FLOAT;
                    end
                end
            end
        endcase
        // host writes update the working copy of each setting
        if (regWrEn && isMapped(regAddr)) begin
            unique case (regAddr)
                OFF_SLOT_LED_SELECT:     d.cfg.ledSelect      = regWrData;
                OFF_SLOT_A_LED_TIMING:   d.cfg.aTiming        = regWrData;
                OFF_SLOT_A_PULSE_PERIOD: d.cfg.aPeriod        = regWrData;
                OFF_SLOT_B_LED_TIMING:   d.cfg.bTiming        = regWrData;
                OFF_SLOT_B_PULSE_PERIOD: d.cfg.bPeriod        = regWrData;
                OFF_PERIOD_HIGH_BITS:    d.cfg.periodHigh     = regWrData;
                OFF_SLOT_A_INTEGRATOR:   d.cfg.aIntegrator    = regWrData;
                OFF_SLOT_B_INTEGRATOR:   d.cfg.bIntegrator    = regWrData;
                OFF_DEFAULT_CATHODE:     d.cfg.defaultCathode = regWrData;
                OFF_SLOT_A_AMP_REF:      d.cfg.aAmpRef        = regWrData;
                OFF_SLOT_B_AMP_REF:      d.cfg.bAmpRef        = regWrData;
                OFF_CATHODE_BIAS:        d.cfg.cathodeBias    = regWrData;
                OFF_PULSE_MATH:          d.cfg.pulseMath      = regWrData;
                OFF_SLOT_B_FLOAT_CTRL:   d.cfg.bFloatCtrl     = regWrData;
                OFF_SLOT_A_FLOAT_CTRL:   d.cfg.aFloatCtrl     = regWrData;
                default: ; // frontend config is only stored
            endcase
        end
        // read path: status snapshot or stored word, unmapped reads zero
        d.rdStatus   = regRdEn && (regAddr == OFF_SEQ_STATUS);
        d.rdMapped   = regRdEn && isMapped(regAddr);
        d.statusSnap = '0;
        d.statusSnap[STAT_PULSE_LSB +: 8] = q.pulseIdx;
        d.statusSnap[STAT_STATE_LSB +: 3] = q.state;
        d.statusSnap[STAT_SLOT_BIT]       = q.slotB;
    end

    // state register
    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign regRdData          = q.rdStatus ? q.statusSnap : (q.rdMapped ? memRdData : '0);
    assign busy               = (q.state != ST_IDLE);
    assign preconditionOn     = (q.state == ST_PRECON);
    assign pdFloating         = (q.state == ST_FLOAT);
    assign pdConnected        = (q.state == ST_PRECON) || (q.state == ST_CONNECT);
    // positive phase opens at the programmed start inside the float interval
    assign integratorPositive = (q.state == ST_FLOAT) && (q.floatCyc >= startCyc);
    assign integratorNegative = (q.state == ST_CONNECT) || (q.state == ST_NEGTAIL);
    assign adcRequest         = q.adcReq;
    assign ampReferenceLevel  = ampRef;
    assign ampReference0v9    = (ampRef == AMPREF_0V9);
    assign cathodeBiasLevel   = cathSel;
    assign reverseBias250mV   = preconditionOn && (cathSel == CATHODE_250MV);
    assign sampleValid        = q.sampleValid;
    assign sampleSlotB        = q.slotB;
    assign sampleData         = q.sampleData;

endmodule // float_ambient_sequencer

/* File: core/float_seq_pkg.sv */
// register map, field layout and timing constants for the float ambient sequencer
package float_seq_pkg;

    // register offsets (8-bit register address space)
    localparam logic [7:0] OFF_SLOT_LED_SELECT     = 8'h14;
    localparam logic [7:0] OFF_SLOT_A_LED_TIMING   = 8'h30;
    localparam logic [7:0] OFF_SLOT_A_PULSE_PERIOD = 8'h31;
    localparam logic [7:0] OFF_SLOT_B_LED_TIMING   = 8'h35;
    localparam logic [7:0] OFF_SLOT_B_PULSE_PERIOD = 8'h36;
    localparam logic [7:0] OFF_PERIOD_HIGH_BITS    = 8'h37;
    localparam logic [7:0] OFF_SLOT_A_INTEGRATOR   = 8'h39;
    localparam logic [7:0] OFF_SLOT_B_INTEGRATOR   = 8'h3b;
    localparam logic [7:0] OFF_DEFAULT_CATHODE     = 8'h3c;
    localparam logic [7:0] OFF_SLOT_A_AMP_REF      = 8'h42;
    localparam logic [7:0] OFF_SLOT_A_FRONTEND     = 8'h43;
    localparam logic [7:0] OFF_SLOT_B_AMP_REF      = 8'h44;
    localparam logic [7:0] OFF_SLOT_B_FRONTEND     = 8'h45;
    localparam logic [7:0] OFF_CATHODE_BIAS        = 8'h54;
    localparam logic [7:0] OFF_PULSE_MATH          = 8'h58;
    localparam logic [7:0] OFF_SLOT_B_FLOAT_CTRL   = 8'h59;
    localparam logic [7:0] OFF_SLOT_A_FLOAT_CTRL   = 8'h5e;
    localparam logic [7:0] OFF_SEQ_STATUS          = 8'h70;

    // storage geometry
    localparam int REG_ADDR_W = 7;
    localparam int REG_DATA_W = 16;

    // field positions
    localparam int LEDSEL_A_LSB    = 0;
    localparam int LEDSEL_B_LSB    = 2;
    localparam int FLTEN_LSB       = 13;
    localparam int PRECON_LSB      = 8;
    localparam int PERIOD_LO_LSB   = 0;
    localparam int PULSES_LSB      = 8;
    localparam int PERIOD_HI_A_LSB = 0;
    localparam int PERIOD_HI_B_LSB = 8;
    localparam int CONNW_LSB       = 8;
    localparam int OFFSET_LSB      = 0;
    localparam int INTW_LSB        = 11;
    localparam int INTSTART_LSB    = 0;
    localparam int AMPREF_LSB      = 4;
    localparam int CATH_A_LSB      = 8;
    localparam int CATH_B_LSB      = 10;
    localparam int CATH_OVR_BIT    = 7;
    localparam int DEFCATH_A_LSB   = 0;
    localparam int DEFCATH_B_LSB   = 2;
    localparam int MATH_A_LSB      = 1;
    localparam int MATH_B_LSB      = 5;

    // field values
    localparam logic [1:0] LED_SEL_FLOAT    = 2'h0;
    localparam logic [1:0] FLOAT_ENABLE_ON  = 2'h3;
    localparam logic [1:0] MATH_SUB1_ADD2   = 2'h2;
    localparam logic [1:0] MATH_ADD1_SUB2   = 2'h1;
    localparam logic [1:0] AMPREF_0V9       = 2'h2;
    localparam logic [1:0] CATHODE_250MV    = 2'h2;

    // timing: clock period, microsecond unit and integrator start step
    localparam int CLOCK_PERIOD_PS = 40000;
    localparam int MICROSECOND_PS  = 1000000;
    localparam int INT_STEP_PS     = 31250;
    localparam int US_CYCLES       = MICROSECOND_PS / CLOCK_PERIOD_PS;

    // status word layout
    localparam int STAT_PULSE_LSB = 0;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_SLOT_BIT  = 11;

    // pulse sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRECON,
        ST_FLOAT,
        ST_CONNECT,
        ST_NEGTAIL,
        ST_CONVERT
    } seq_state_t;

endpackage

/* File: core/reg_store.sv */
// small register memory with registered read data
`timescale 1ns/1ps
module reg_store #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 16
) (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);

    logic [DATA_W-1:0] mem [2**ADDR_W]; // word storage, contents undefined until written

    // write port
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // read port, data held in a register
    always_ff @(posedge clock) begin
        if (srst) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule // reg_store

/* File: tb/float_seq_sva.sv */
// port-level checker for the float ambient sequencer
`timescale 1ns/1ps
module float_seq_sva
    import float_seq_pkg::*;
(
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       sampleStart,
    input wire logic       busy,
    input wire logic       preconditionOn,
    input wire logic       pdFloating,
    input wire logic       pdConnected,
    input wire logic       integratorPositive,
    input wire logic       integratorNegative,
    input wire logic       adcRequest,
    input wire logic [1:0] ampReferenceLevel,
    input wire logic       ampReference0v9,
    input wire logic [1:0] cathodeBiasLevel,
    input wire logic       reverseBias250mV,
    input wire logic       sampleValid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // float keeps the diode off the receive path
    a_float_apart: assert property (pdFloating |-> !pdConnected && !integratorNegative)
        else $error("float overlap");
    a_dump_negative: assert property (pdConnected && !preconditionOn |-> integratorNegative)
        else $error("dump not negative");
    a_positive_float: assert property (integratorPositive |-> pdFloating)
        else $error("positive outside float");
    a_bias_250: assert property (reverseBias250mV == (preconditionOn && cathodeBiasLevel == CATHODE_250MV))
        else $error("bias flag");
    a_ref_level: assert property (ampReference0v9 == (ampReferenceLevel == AMPREF_0V9))
        else $error("reference flag");
    a_start_precon: assert property ($rose(busy) |-> $past(sampleStart) && preconditionOn)
        else $error("bad start");
    a_valid_once: assert property (sampleValid |=> !sampleValid)
        else $error("valid twice");
    a_adc_convert: assert property (adcRequest |-> !pdFloating && !pdConnected ##1 !adcRequest)
        else $error("request misplaced");
    a_idle_quiet: assert property (!busy |-> !pdFloating && !pdConnected && !preconditionOn)
        else $error("phase while idle");
    c_sample: cover property (sampleValid);
    c_bias: cover property ($rose(reverseBias250mV));
    c_positive: cover property (integratorPositive);
endmodule // float_seq_sva

bind float_ambient_sequencer float_seq_sva u_sva (.*);

/* File: tb/adc_model.sv */
// converter stand-in: answers each request, promptly or slowly
`timescale 1ns/1ps
module adc_model (
    input  wire logic        clock,
    input  wire logic        restart,
    input  wire logic        adcRequest,
    input  wire logic        slow,
    input  wire logic [19:0] base,
    input  wire logic [19:0] step,
    output logic             adcValid = 1'b0,
    output logic      [19:0] adcResult = 20'h00000
);
    int waitN = -1;  // cycles left before answering
    int idx   = 0;   // pulse index within the sample
    // result k is base plus k steps; while no request is pending the bus toggles
    always @(posedge clock) begin
        adcValid <= 1'b0;
        if (restart) idx = 0;
        if (adcRequest) waitN = slow ? 9 : 1;
        else if (waitN > 0) waitN--;
        else if (waitN == 0) begin
            adcValid <= 1'b1;
            adcResult <= base + 20'(idx) * step;
            idx++;
            waitN = -1;
        end else adcResult <= ~adcResult;
    end
endmodule // adc_model

/* File: tb/float_ambient_sequencer_bench.sv */
// self-checking bench: registers, phase lengths and pulse math
`timescale 1ns/1ps
module float_ambient_sequencer_bench;
    import float_seq_pkg::*;
    logic        clock = 1'b0, srst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic        sampleStart = 1'b0, slotSelB = 1'b0, slow = 1'b0, adcValid, busy;
    logic        preconditionOn, pdFloating, pdConnected, integratorPositive;
    logic        integratorNegative, adcRequest, ampReference0v9, reverseBias250mV;
    logic        sampleValid, sampleSlotB;
    logic [1:0]  ampReferenceLevel, cathodeBiasLevel;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, regRdData, rdv;
    logic [19:0] adcResult, base = 20'h00000, step = 20'h00000;
    logic [26:0] sampleData;
    logic [31:0] lfsr = 32'hfb06;
    int          mismatches = 0, num_checks = 0, preN = 0, fltN = 0, conN = 0;
    int          preQ[$], fltQ[$], conQ[$];
    int          preT[2] = '{2, 1}, f1T[2] = '{6, 9}, perT[2] = '{10, 268}, cwT[2] = '{2, 3};

    float_ambient_sequencer u_dut (.*);
    adc_model u_adc (.clock, .restart(sampleStart && !busy), .adcRequest, .slow, .base,
        .step, .adcValid, .adcResult);

    initial forever #20 clock = ~clock;

    // run lengths of precondition, float and dump phases
    always @(posedge clock) begin
        if (preconditionOn) preN++;
        else if (preN > 0) begin preQ.push_back(preN); preN = 0; end
        if (pdFloating) fltN++;
        else if (fltN > 0) begin fltQ.push_back(fltN); fltN = 0; end
        if (pdConnected && !preconditionOn) conN++;
        else if (conN > 0) begin conQ.push_back(conN); conN = 0; end
    end

    function automatic logic [31:0] nxt();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // signed sum of all pulse results with the programmed signs
    function automatic logic [26:0] expect_sum(input logic [1:0] m, input int np);
        logic signed [26:0] acc = '0, v;
        for (int k = 0; k < (np == 0 ? 1 : np); k++) begin
            v = $signed(20'(base + 20'(k) * step));
            if ((k == 0 && m == MATH_SUB1_ADD2) || (k == 1 && m == MATH_ADD1_SUB2)) acc -= v;
            else acc += v;
        end
        return acc;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock); regWrEn <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge clock); regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock); regRdEn <= 1'b1; regAddr <= a;
        @(posedge clock); regRdEn <= 1'b0;
        @(negedge clock); rdv = regRdData;
    endtask
    task automatic start(input logic sb);
        @(posedge clock); sampleStart <= 1'b1; slotSelB <= sb;
        @(posedge clock); sampleStart <= 1'b0;
    endtask
    // one sample with a second, refused request in mid-run
    task automatic run(input logic sb, input logic [1:0] m, input int np);
        bit done = 0;
        wr(sb ? 8'h36 : 8'h31, {8'(np), sb ? 8'd12 : 8'd10});
        wr(OFF_PULSE_MATH, {9'h000, m, 2'h0, m, 1'b0});
        void'(nxt());
        base <= {6'h00, lfsr[13:0]} - 20'h02000; step <= {12'h000, lfsr[23:16]}; slow <= lfsr[5];
        preQ.delete(); fltQ.delete(); conQ.delete();
        start(sb);
        repeat (40) @(posedge clock);
        start(!sb);
        for (int i = 0; i < 40000 && !done; i++) begin @(negedge clock); done = sampleValid === 1'b1; end
        if (!done) begin mismatches++; tally_and_finish(); end
        chk("sampleData", expect_sum(m, np), sampleData);
        chk("sampleSlotB", sb, sampleSlotB);
        chk("preRun", preT[sb] * 25 + 1, preQ[0]);
        chk("fltRun0", f1T[sb] * 25 + 1, fltQ[0]);
        for (int k = 1; k < np; k++) chk("fltRun", perT[sb] * 25 + 1, fltQ[k]);
        chk("conRun", cwT[sb] * 25 + 1, conQ[0]);
    endtask

    initial begin
        logic [7:0] offs[17] = '{8'h14, 8'h30, 8'h31, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3b, 8'h3c,
                                 8'h42, 8'h43, 8'h44, 8'h45, 8'h54, 8'h58, 8'h59, 8'h5e};
        int cs[6][3] = '{'{0, 2, 2}, '{1, 2, 2}, '{0, 1, 2}, '{1, 0, 3}, '{0, 3, 1}, '{0, 2, 0}};
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        foreach (offs[i]) begin void'(nxt()); wr(offs[i], lfsr[15:0]); rd(offs[i]); chk("reg", lfsr[15:0], rdv); end
        wr(OFF_SEQ_STATUS, 16'hffff); rd(OFF_SEQ_STATUS); chk("status", 0, rdv);
        rd(8'h20); chk("unmapped", 0, rdv);
        wr(8'h42, 16'h0020); wr(8'h44, 16'h0010); wr(8'h3c, 16'h0001); wr(8'h54, 16'h0200);
        repeat (2) @(negedge clock);
        chk("ampLevel", 2, ampReferenceLevel);
        chk("cathode", 1, cathodeBiasLevel);
        wr(8'h54, 16'h0280); repeat (2) @(negedge clock); chk("cathodeOvr", 2, cathodeBiasLevel);
        @(posedge clock); slotSelB <= 1'b1;
        repeat (2) @(negedge clock); chk("ampLevelB", 1, ampReferenceLevel);
        wr(8'h5e, 16'h6200); wr(8'h59, 16'h6100); wr(8'h37, 16'h0100); wr(8'h30, 16'h0206);
        wr(8'h35, 16'h0307); wr(8'h39, 16'h1820); wr(8'h3b, 16'h2020); wr(8'h54, 16'h0a80);
        wr(8'h43, 16'hae65); wr(8'h45, 16'hae65);
        wr(8'h14, 16'h0001); start(1'b0); repeat (5) @(negedge clock); chk("refused", 0, busy);
        wr(8'h14, 16'h0000);
        foreach (cs[i]) run(cs[i][0], cs[i][1], cs[i][2]);
        tally_and_finish();
    end
endmodule // float_ambient_sequencer_bench
